// ===== include/iobh_defines.vh
// Timing, opcode and cycle constants for the I/O bus handshake block
`ifndef IOBH_DEFINES_VH
`define IOBH_DEFINES_VH

`define IOBH_DATA_W        16
`define IOBH_UNIT_W        6
`define IOBH_UNIT_COUNT    64
`define IOBH_OP_W          4

`define IOBH_CLK_NS        50
`define IOBH_TPULSE_NS     50
`define IOBH_T_PER_CYCLE   4'hF
`define IOBH_ICLK_NS       125
`define IOBH_ICLK_CYC      ((`IOBH_ICLK_NS + `IOBH_CLK_NS - 1) / `IOBH_CLK_NS)
`define IOBH_ICLK_START_T  5

`define IOBH_CYC_I         2'h0
`define IOBH_CYC_E1        2'h1
`define IOBH_CYC_E2        2'h2

`define IOBH_OP_AUG        4'h0
`define IOBH_OP_MEMREF     4'h1
`define IOBH_OP_IMS        4'h2
`define IOBH_OP_CMA        4'h3
`define IOBH_OP_CEU        4'h8
`define IOBH_OP_TEU        4'h9
`define IOBH_OP_MOP        4'hA
`define IOBH_OP_MIP        4'hB
`define IOBH_OP_AOP        4'hC
`define IOBH_OP_AIP        4'hD

`define IOBH_SPB_IND_OP    16'hA400
`define IOBH_INT_VEC_IN    16'h0020
`define IOBH_INT_VEC_OUT   16'h0021

`define IOBH_FIFO_DEPTH    16
`define IOBH_FIFO_AW       4

`endif

// ===== rtl/iobh_io_bus.v
// I/O processor handshake with cycle generator and input word FIFO
`timescale 1ns/1ns
`include "iobh_defines.vh"

module iobh_fifo
#(
	parameter W  = 17,
	parameter D  = `IOBH_FIFO_DEPTH,
	parameter AW = `IOBH_FIFO_AW
)
(
	input  wire         i_clk,
	input  wire         i_rstn,
	input  wire         i_in_valid,
	output wire         o_in_ready,
	input  wire [W-1:0] i_in_data,
	output wire         o_out_valid,
	input  wire         i_out_ready,
	output wire [W-1:0] o_out_data
);
	reg  [W-1:0] mem [0:D-1];
	reg  [AW-1:0] wr_q;
	reg  [AW-1:0] rd_q;
	reg  [AW:0]   cnt_q;
	wire          push;
	wire          pop;

	assign o_in_ready  = (cnt_q != D[AW:0]);
	assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_q];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always @(posedge i_clk)
	begin
		if (push)
			mem[wr_q] <= i_in_data;
	end

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
			if (push && !pop)
				cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
			else if (pop && !push)
				cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule

// Overview of operation
// - Sixteen two-way data lines, six unit lines and control lines carry every word.
// - Six unit lines select one of up to 64 peripherals.
// - Start drives unit number, instruction sync and instruction-class lines.
// - Test return is sampled only after sync return is seen; high means ready.
// - Ready units transfer under data-here and data-accepted; input ready means data present.
// - After transfer, returns must go inactive before the next instruction starts.
// - Immediate-mode I/O instructions finish in four machine cycles.
// - Wait flag holds the instruction until the unit reports ready.
// - Unit test sends its word without ready check, then samples test return.
// - Class lines per instruction type; wait flag never accompanies unit test.
// - Output, command and test transfers strobe data-here; peripheral acknowledges.
// - Input transfers issue data-accepted once the word has been taken.
// - Master clear and a 150 ns (three-clock) interface clock pulse every I/O machine cycle.
// - Taken interrupt forces its vector into transfer register and branch opcode.
// - Memory-reference goes I, E1, I; increment-skip and compare add E2.
// - Each machine cycle is fifteen 50 ns T pulses.
// - Direction line high for the two input instructions, low otherwise.
module iobh_io_bus
#(
	parameter DW = `IOBH_DATA_W,
	parameter UW = `IOBH_UNIT_W,
	parameter FD = `IOBH_FIFO_DEPTH,
	parameter FA = `IOBH_FIFO_AW
)
(
	input  wire                 i_clk,
	input  wire                 i_rstn,
	input  wire                 i_start,
	output wire                 o_start_ready,
	input  wire [`IOBH_OP_W-1:0] i_op,
	input  wire [UW-1:0]        i_unit,
	input  wire                 i_wait,
	input  wire [DW-1:0]        i_wdata,
	output reg                  o_done,
	output reg                  o_result,
	output wire                 o_busy,
	output wire                 o_rd_valid,
	input  wire                 i_rd_ready,
	output wire [DW-1:0]        o_rd_data,
	output wire                 o_rd_to_acc,
	input  wire                 i_master_clear,
	input  wire [1:0]           i_int_take,
	output reg  [DW-1:0]        o_ir,
	output reg  [DW-1:0]        o_tr,
	output wire [1:0]           o_cycle,
	output wire [3:0]           o_tpulse,
	output reg  [UW-1:0]        o_unit,
	output reg                  o_isync,
	output reg                  o_data_cls,
	output reg                  o_cmd_cls,
	output reg                  o_test_cls,
	output reg                  o_io_dir,
	output reg                  o_wait_flag,
	output reg                  o_data_here,
	output reg                  o_data_acc,
	output reg                  o_iclk,
	output reg                  o_mclr,
	input  wire [DW-1:0]        i_bus_data,
	output reg  [DW-1:0]        o_bus_data,
	output reg                  o_bus_data_oe_n,
	input  wire                 i_usync_ret,
	input  wire                 i_utest_ret,
	input  wire                 i_udacc
);
	localparam PH_IDLE  = 3'h0;
	localparam PH_FETCH = 3'h1;
	localparam PH_E1    = 3'h2;
	localparam PH_E2    = 3'h3;
	localparam PH_ISSUE = 3'h4;
	localparam PH_QUERY = 3'h5;
	localparam PH_XFER  = 3'h6;
	localparam PH_CHK   = 3'h7;

	function is_io;
		input [`IOBH_OP_W-1:0] op;
		begin
			is_io = op[3];
		end
	endfunction

	function is_input;
		input [`IOBH_OP_W-1:0] op;
		begin
			is_input = (op == `IOBH_OP_MIP) || (op == `IOBH_OP_AIP);
		end
	endfunction

	reg  [3:0]            t_q;
	reg  [2:0]            ph_q;
	reg  [2:0]            ph_d;
	reg  [`IOBH_OP_W-1:0] op_q;
	reg                   wait_q;
	reg  [DW-1:0]         wdata_q;
	reg                   seen_q;
	reg                   rdy_q;
	reg                   xdone_q;
	reg  [1:0]            step_q;
	reg  [2:0]            sync_m;
	reg  [2:0]            sync_s;
	reg  [DW-1:0]         bus_m;
	reg  [DW-1:0]         bus_s;
	wire                  usync_s;
	wire                  utest_s;
	wire                  udacc_s;
	wire                  t_end;
	wire                  hold;
	wire                  take;
	wire                  advance;
	wire                  io_act;
	wire                  f_in_ready;
	wire                  push;
	wire                  op_teu;
	wire                  op_in;

	assign usync_s = sync_s[0];
	assign utest_s = sync_s[1];
	assign udacc_s = sync_s[2];
	assign op_teu  = (op_q == `IOBH_OP_TEU);
	assign op_in   = is_input(op_q);
	assign t_end   = (t_q == `IOBH_T_PER_CYCLE);
	assign io_act  = ph_q[2];
	assign hold    = ((ph_q == PH_XFER) && !xdone_q) ||
	                 ((ph_q == PH_CHK) && (usync_s || utest_s || udacc_s));
	assign advance = t_end && !hold;
	assign o_start_ready = (ph_q == PH_IDLE) && t_end && !i_master_clear &&
	                       (!is_input(i_op) || f_in_ready);
	assign take    = i_start && o_start_ready;
	assign o_busy  = (ph_q != PH_IDLE);
	assign o_tpulse = t_q;
	assign o_cycle = ((ph_q == PH_E1) || (ph_q == PH_XFER)) ? `IOBH_CYC_E1 :
	                 ((ph_q == PH_E2) || (ph_q == PH_CHK)) ? `IOBH_CYC_E2 : `IOBH_CYC_I;
	assign push    = (ph_q == PH_XFER) && op_in && rdy_q && (step_q == 2'h0) &&
	                 f_in_ready && !xdone_q;

	// Return lines and data bus come from cables: two stages before use
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sync_m <= 3'h0;
			sync_s <= 3'h0;
			bus_m  <= {DW{1'b0}};
			bus_s  <= {DW{1'b0}};
		end
		else
		begin
			sync_m <= {i_udacc, i_utest_ret, i_usync_ret};
			sync_s <= sync_m;
			bus_m  <= i_bus_data;
			bus_s  <= bus_m;
		end
	end

	// T pulse counter; stretched at T15 while a handshake is pending
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			t_q <= 4'h1;
		else if (advance)
			t_q <= 4'h1;
		else if (!t_end)
			t_q <= t_q + 4'h1;
	end

	always @*
	begin
		ph_d = ph_q;
		if (advance)
		begin
			case (ph_q)
				PH_IDLE:
					if (take)
						ph_d = is_io(i_op) ? PH_ISSUE : PH_FETCH;
				PH_FETCH:
					if (op_q == `IOBH_OP_AUG)
						ph_d = PH_IDLE;
					else
						ph_d = PH_E1;
				PH_E1:
					if ((op_q == `IOBH_OP_IMS) || (op_q == `IOBH_OP_CMA))
						ph_d = PH_E2;
					else
						ph_d = PH_IDLE;
				PH_E2:
					ph_d = PH_IDLE;
				PH_ISSUE:
					ph_d = PH_QUERY;
				PH_QUERY:
					if (seen_q && (!wait_q || rdy_q))
						ph_d = PH_XFER;
				PH_XFER:
					ph_d = PH_CHK;
				PH_CHK:
					ph_d = PH_IDLE;
				default:
					ph_d = PH_IDLE;
			endcase
		end
		if (i_master_clear)
			ph_d = PH_IDLE;
	end

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ph_q    <= PH_IDLE;
			op_q    <= `IOBH_OP_AUG;
			wait_q  <= 1'b0;
			wdata_q <= {DW{1'b0}};
			o_done  <= 1'b0;
			o_result <= 1'b0;
		end
		else
		begin
			ph_q   <= ph_d;
			o_done <= advance && !i_master_clear &&
			          (((ph_q == PH_FETCH) && (op_q == `IOBH_OP_AUG)) ||
			           ((ph_q == PH_E1) && (ph_d == PH_IDLE)) ||
			           (ph_q == PH_E2) || (ph_q == PH_CHK));
			if (advance && (ph_q == PH_CHK))
				o_result <= rdy_q;
			if (take)
			begin
				op_q    <= i_op;
				wait_q  <= i_wait && (i_op != `IOBH_OP_TEU);
				wdata_q <= i_wdata;
			end
		end
	end

	// Query cycle: test return only counts once sync return is seen
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			seen_q  <= 1'b0;
			rdy_q   <= 1'b0;
			xdone_q <= 1'b0;
			step_q  <= 2'h0;
		end
		else if (ph_q == PH_ISSUE)
		begin
			seen_q  <= 1'b0;
			rdy_q   <= 1'b0;
			xdone_q <= 1'b0;
			step_q  <= 2'h0;
		end
		else if (ph_q == PH_QUERY)
		begin
			if (advance && (ph_d == PH_QUERY))
				seen_q <= 1'b0;
			else if (usync_s && !seen_q)
			begin
				seen_q <= 1'b1;
				rdy_q  <= utest_s;
			end
		end
		else if ((ph_q == PH_XFER) && !xdone_q)
		begin
			if (!op_teu && !rdy_q)
				xdone_q <= 1'b1;
			else if (op_in)
			begin
				if (push)
					xdone_q <= 1'b1;
			end
			else
			begin
				case (step_q)
					2'h0:
						step_q <= 2'h1;
					2'h1:
						if (udacc_s)
							step_q <= 2'h2;
					2'h2:
					begin
						if (op_teu)
							rdy_q <= utest_s;
						xdone_q <= 1'b1;
					end
					default:
						step_q <= 2'h0;
				endcase
			end
		end
	end

	// Bus control lines
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_unit          <= {UW{1'b0}};
			o_isync         <= 1'b0;
			o_data_cls      <= 1'b0;
			o_cmd_cls       <= 1'b0;
			o_test_cls      <= 1'b0;
			o_io_dir        <= 1'b0;
			o_wait_flag     <= 1'b0;
			o_data_here     <= 1'b0;
			o_data_acc      <= 1'b0;
			o_iclk          <= 1'b0;
			o_mclr          <= 1'b1;
			o_bus_data      <= {DW{1'b0}};
			o_bus_data_oe_n <= 1'b1;
		end
		else
		begin
			o_mclr <= i_master_clear;
			o_iclk <= io_act &&
			          (t_q >= (`IOBH_ICLK_START_T - 1)) &&
			          (t_q < (`IOBH_ICLK_START_T - 1 + `IOBH_ICLK_CYC));
			if ((ph_d == PH_ISSUE) && (ph_q == PH_IDLE))
			begin
				o_unit      <= i_unit;
				o_isync     <= 1'b1;
				o_data_cls  <= i_op >= `IOBH_OP_MOP;
				o_cmd_cls   <= (i_op == `IOBH_OP_CEU);
				o_test_cls  <= (i_op == `IOBH_OP_TEU);
				o_io_dir    <= is_input(i_op);
				o_wait_flag <= i_wait && (i_op != `IOBH_OP_TEU);
			end
			else if ((ph_d == PH_CHK) || (ph_d == PH_IDLE))
			begin
				o_isync     <= 1'b0;
				o_data_cls  <= 1'b0;
				o_cmd_cls   <= 1'b0;
				o_test_cls  <= 1'b0;
				o_wait_flag <= 1'b0;
				o_io_dir    <= 1'b0;
			end
			if (ph_d == PH_IDLE)
			begin
				o_unit   <= {UW{1'b0}};
			end
			o_data_here <= (ph_q == PH_XFER) && !op_in && !xdone_q &&
			               (op_teu || rdy_q) && (step_q != 2'h2) &&
			               !(step_q == 2'h1 && udacc_s);
			if (push)
				o_data_acc <= 1'b1;
			else if (ph_d != PH_XFER)
				o_data_acc <= 1'b0;
			o_bus_data      <= wdata_q;
			o_bus_data_oe_n <= !(io_act && (ph_q != PH_CHK) && !op_in);
		end
	end

	// Interrupt entry forces the vector and the branch opcode together
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_ir <= {DW{1'b0}};
			o_tr <= {DW{1'b0}};
		end
		else if (i_int_take != 2'h0)
		begin
			o_ir <= `IOBH_SPB_IND_OP;
			o_tr <= i_int_take[0] ? `IOBH_INT_VEC_IN : `IOBH_INT_VEC_OUT;
		end
	end

	iobh_fifo
	#(
		.W  (DW + 1),
		.D  (FD),
		.AW (FA)
	)
	u_fifo
	(
		.i_clk       (i_clk),
		.i_rstn      (i_rstn),
		.i_in_valid  (push),
		.o_in_ready  (f_in_ready),
		.i_in_data   ({(op_q == `IOBH_OP_AIP), bus_s}),
		.o_out_valid (o_rd_valid),
		.i_out_ready (i_rd_ready),
		.o_out_data  ({o_rd_to_acc, o_rd_data})
	);
endmodule

// ===== testbench/iobh_io_bus_assertions.sv
// Checker of the I/O bus handshake outputs
`timescale 1ns/1ns

module iobh_chk
(
	input wire		i_clk,
	input wire		i_rstn,
	input wire		i_master_clear,
	input wire		o_mclr,
	input wire		o_done,
	input wire		o_isync,
	input wire		o_data_cls,
	input wire		o_cmd_cls,
	input wire		o_test_cls,
	input wire		o_io_dir,
	input wire		o_wait_flag,
	input wire		o_data_here,
	input wire		o_data_acc,
	input wire		o_iclk,
	input wire		o_bus_data_oe_n,
	input wire [3:0]	o_tpulse,
	input wire		i_usync_ret,
	input wire		i_utest_ret,
	input wire		i_udacc
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn || i_master_clear || o_mclr);
	sequence s_iclk;
		o_iclk [*3] ##1 !o_iclk;
	endsequence
	sequence s_idle;
		!o_isync && !o_data_here && !o_data_acc && o_bus_data_oe_n;
	endsequence
	property p_cmd;
		o_cmd_cls |-> !o_data_cls && !o_test_cls && !o_io_dir;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command class mixed");
	property p_tst;
		o_test_cls |-> !o_wait_flag && !o_data_cls && !o_io_dir;
	endproperty
	a_tst: assert property (p_tst) else $error("test class mixed");
	property p_dir;
		o_io_dir |-> o_data_cls && o_isync;
	endproperty
	a_dir: assert property (p_dir) else $error("input line without data class");
	property p_cls;
		o_isync |-> o_data_cls || o_cmd_cls || o_test_cls;
	endproperty
	a_cls: assert property (p_cls) else $error("sync without class");
	property p_dh;
		o_data_here |-> o_isync && !o_io_dir && !o_bus_data_oe_n;
	endproperty
	a_dh: assert property (p_dh) else $error("data here misplaced");
	property p_da;
		o_data_acc |-> o_isync && o_io_dir && o_bus_data_oe_n;
	endproperty
	a_da: assert property (p_da) else $error("data accepted misplaced");
	property p_iclk;
		$rose(o_iclk) |-> s_iclk;
	endproperty
	a_iclk: assert property (p_iclk) else $error("clock pulse not 3 cycles");
	property p_tp;
		o_tpulse != 4'hF |=> o_tpulse == $past(o_tpulse) + 4'h1;
	endproperty
	a_tp: assert property (p_tp) else $error("time pulse skipped");
	property p_fin;
		$fell(o_isync) |-> ##[1:200] o_done;
	endproperty
	a_fin: assert property (p_fin) else $error("no done after sync drop");
	property p_done;
		o_done |-> s_idle;
	endproperty
	a_done: assert property (p_done) else $error("done with bus still active");
	property p_rel;
		o_done |-> !$past(i_usync_ret, 3) && !$past(i_utest_ret, 3) && !$past(i_udacc, 3);
	endproperty
	a_rel: assert property (p_rel) else $error("done with returns active");
endmodule

bind iobh_io_bus iobh_chk chk (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_master_clear(i_master_clear), .o_mclr(o_mclr), .o_done(o_done), .o_isync(o_isync),
	.o_data_cls(o_data_cls), .o_cmd_cls(o_cmd_cls), .o_test_cls(o_test_cls),
	.o_io_dir(o_io_dir), .o_wait_flag(o_wait_flag), .o_data_here(o_data_here),
	.o_data_acc(o_data_acc), .o_iclk(o_iclk), .o_bus_data_oe_n(o_bus_data_oe_n),
	.o_tpulse(o_tpulse), .i_usync_ret(i_usync_ret), .i_utest_ret(i_utest_ret),
	.i_udacc(i_udacc));

// ===== testbench/iobh_periph_model.sv
// Peripheral on the far side of the I/O bus
`timescale 1ns/1ns

module iobh_periph_model
#(
	parameter [5:0]	UNIT = 6'h2A
)
(
	input wire		i_clk,
	input wire		i_isync,
	input wire [5:0]	i_unit,
	input wire		i_wait_flag,
	input wire		i_test_cls,
	input wire		i_io_dir,
	input wire		i_data_here,
	input wire [15:0]	i_bus,
	input wire		i_ready,
	input wire [15:0]	i_stat,
	input wire [15:0]	i_rdata,
	input wire [3:0]	i_dly,
	output reg		o_usync,
	output reg		o_utest,
	output reg		o_udacc,
	output reg [15:0]	o_data,
	output reg [15:0]	o_got
);
	wire		sel = i_isync && i_unit == UNIT;
	wire		hit;
	reg [3:0]	cnt;
	assign hit = sel && i_data_here && cnt == i_dly;
	initial
	begin
		o_usync = 1'h0;
		o_utest = 1'h0;
		o_udacc = 1'h0;
		o_data = 16'h0;
		o_got = 16'h0;
		cnt = 4'h0;
	end
	always @(posedge i_clk)
	begin
		o_usync <= sel && (!i_wait_flag || i_ready);
		o_utest <= sel && (i_test_cls ? |(i_bus & i_stat) : i_ready);
		cnt <= (sel && i_data_here && cnt != i_dly) ? cnt + 4'h1 : (hit ? cnt : 4'h0);
		o_udacc <= hit;
		if (hit)
			o_got <= i_bus;
		// Released lines toggle so a stale value is never read
		o_data <= (sel && i_io_dir) ? i_rdata : ~o_data;
	end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the I/O bus handshake block
`timescale 1ns/1ns
`include "iobh_defines.vh"

module testbench;
	logic		i_clk, i_rstn, i_start, i_wait, i_rd_ready, i_master_clear;
	logic		p_ready, hit;
	logic [3:0]	i_op, p_dly;
	logic [5:0]	i_unit;
	logic [1:0]	i_int_take, mx;
	logic [15:0]	i_wdata, p_stat, p_rdat;
	wire		o_start_ready, o_done, o_result, o_busy, o_rd_valid, o_rd_to_acc;
	wire		o_isync, o_data_cls, o_cmd_cls, o_test_cls, o_io_dir, o_wait_flag;
	wire		o_data_here, o_data_acc, o_iclk, o_mclr, o_bus_data_oe_n;
	wire		i_usync_ret, i_utest_ret, i_udacc;
	wire [1:0]	o_cycle;
	wire [3:0]	o_tpulse;
	wire [5:0]	o_unit;
	wire [15:0]	o_rd_data, o_ir, o_tr, o_bus_data, p_data, p_got, i_bus_data;
	integer		n_errors, n_compared, cyc, k;

	// Shared data lines: the block drives them while its enable is low
	assign i_bus_data = o_bus_data_oe_n ? p_data : o_bus_data;
	iobh_io_bus dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start),
		.o_start_ready(o_start_ready), .i_op(i_op), .i_unit(i_unit), .i_wait(i_wait),
		.i_wdata(i_wdata), .o_done(o_done), .o_result(o_result), .o_busy(o_busy),
		.o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data),
		.o_rd_to_acc(o_rd_to_acc), .i_master_clear(i_master_clear),
		.i_int_take(i_int_take), .o_ir(o_ir), .o_tr(o_tr), .o_cycle(o_cycle),
		.o_tpulse(o_tpulse), .o_unit(o_unit), .o_isync(o_isync), .o_data_cls(o_data_cls),
		.o_cmd_cls(o_cmd_cls), .o_test_cls(o_test_cls), .o_io_dir(o_io_dir),
		.o_wait_flag(o_wait_flag), .o_data_here(o_data_here), .o_data_acc(o_data_acc),
		.o_iclk(o_iclk), .o_mclr(o_mclr), .i_bus_data(i_bus_data),
		.o_bus_data(o_bus_data), .o_bus_data_oe_n(o_bus_data_oe_n),
		.i_usync_ret(i_usync_ret), .i_utest_ret(i_utest_ret), .i_udacc(i_udacc));
	iobh_periph_model peer (.i_clk(i_clk), .i_isync(o_isync), .i_unit(o_unit),
		.i_wait_flag(o_wait_flag), .i_test_cls(o_test_cls), .i_io_dir(o_io_dir),
		.i_data_here(o_data_here), .i_bus(i_bus_data), .i_ready(p_ready),
		.i_stat(p_stat), .i_rdata(p_rdat), .i_dly(p_dly), .o_usync(i_usync_ret),
		.o_utest(i_utest_ret), .o_udacc(i_udacc), .o_data(p_data), .o_got(p_got));

	initial
	begin
		i_clk = 1'h0;
		forever #25 i_clk = ~i_clk;
	end
	task chk(input [15:0] got, input [15:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task fin(input integer lim);
	begin
		cyc = 0;
		hit = 1'h0;
		mx = 2'h0;
		while (!hit && cyc < lim)
		begin
			@(posedge i_clk);
			#5;
			cyc = cyc + 1;
			hit = o_done === 1'h1;
			if (o_cycle > mx)
				mx = o_cycle;
		end
	end
	endtask
	task go(input [3:0] op, input [5:0] u, input w, input [15:0] d, input integer lim);
	begin
		i_op = op;
		i_unit = u;
		i_wait = w;
		i_wdata = d;
		i_start = 1'h1;
		for (cyc = 0; o_start_ready !== 1'h1 && cyc < 100; cyc = cyc + 1)
			@(posedge i_clk) #5;
		chk(o_start_ready, 16'h1);
		@(posedge i_clk) #5;
		i_start = 1'h0;
		fin(lim);
	end
	endtask
	task t_cyc;
		for (k = 0; k < 4; k = k + 1)
		begin
			go(4'(k), 6'h2A, 1'h0, 16'h0, 100);
			chk(mx, (k > 2) ? 16'h2 : 16'(k));
			chk(16'(cyc), (k == 0) ? 16'h0F : ((k == 1) ? 16'h1E : 16'h2D));
		end
	endtask
	task t_out;
		for (k = 0; k < 3; k = k + 1)
		begin
			p_dly = 4'(k * 3);
			go(k == 0 ? 4'h8 : (k == 1 ? 4'hA : 4'hC), 6'h2A, k[0], 16'(16'h5A00 + k), 300);
			chk(16'(cyc), 16'h3C);
			chk(o_result, 16'h1);
			chk(p_got, 16'(16'h5A00 + k));
		end
	endtask
	task t_notready;
	begin
		p_ready = 1'h0;
		go(4'h8, 6'h2A, 1'h0, 16'h0F0F, 300);
		chk(o_result, 16'h0);
		chk(p_got, 16'h5A02);
	end
	endtask
	task t_wait;
	begin
		go(4'hA, 6'h2A, 1'h1, 16'h3C3C, 150);
		chk(hit, 16'h0);
		p_ready = 1'h1;
		fin(300);
		chk(hit, 16'h1);
		chk(p_got, 16'h3C3C);
	end
	endtask
	task t_teu;
	begin
		p_ready = 1'h0;
		p_stat = 16'h0010;
		go(4'h9, 6'h2A, 1'h1, 16'h0010, 300);
		chk(hit, 16'h1);
		chk(o_result, 16'h1);
		go(4'h9, 6'h2A, 1'h0, 16'h0001, 300);
		chk(o_result, 16'h0);
		chk(p_got, 16'h0001);
		p_ready = 1'h1;
	end
	endtask
	task t_fifo;
	begin
		for (k = 0; k < 16; k = k + 1)
		begin
			p_rdat = 16'(16'h1100 + k);
			go(k[0] ? 4'hD : 4'hB, 6'h2A, 1'h0, 16'h0, 300);
			chk(hit, 16'h1);
		end
		i_op = 4'hB;
		hit = 1'h0;
		repeat (40) @(posedge i_clk) #5 hit = hit | o_start_ready;
		chk(hit, 16'h0);
		for (k = 0; k < 16; k = k + 1)
		begin
			chk(o_rd_data, 16'(16'h1100 + k));
			chk(o_rd_to_acc, 16'(k & 1));
			i_rd_ready = 1'h1;
			@(posedge i_clk) #5;
			i_rd_ready = 1'h0;
			@(posedge i_clk) #5;
		end
		chk(o_rd_valid, 16'h0);
	end
	endtask
	task t_int;
	begin
		i_int_take = 2'h3;
		@(posedge i_clk) #5;
		chk(o_ir, `IOBH_SPB_IND_OP);
		chk(o_tr, `IOBH_INT_VEC_IN);
		i_int_take = 2'h2;
		@(posedge i_clk) #5;
		i_int_take = 2'h0;
		chk(o_tr, `IOBH_INT_VEC_OUT);
	end
	endtask
	task t_nounit;
	begin
		go(4'h8, 6'h15, 1'h0, 16'h0001, 120);
		chk(hit, 16'h0);
		i_master_clear = 1'h1;
		repeat (4) @(posedge i_clk) #5;
		chk(o_mclr, 16'h1);
		chk(o_busy, 16'h0);
		i_master_clear = 1'h0;
	end
	endtask
	initial
	begin
		n_errors = 0;
		n_compared = 0;
		{i_rstn, i_start, i_op, i_unit, i_wait, i_wdata, i_rd_ready} = 0;
		{i_master_clear, i_int_take, p_stat, p_rdat, p_dly} = 0;
		p_ready = 1'h1;
		repeat (5) @(posedge i_clk);
		#5 i_rstn = 1'h1;
		t_cyc;
		t_out;
		t_notready;
		t_wait;
		t_teu;
		t_fifo;
		t_nounit;
		t_int;
		end_of_test;
	end
	initial
	begin
		#(20000 * 50);
		n_errors = n_errors + 1;
		end_of_test;
	end
endmodule
